// ---- inc/burst_sram_pkg.sv ----
package burst_sram_pkg;
  localparam int ADDR_W        = 19;
  localparam int BURST_W       = 2;
  localparam int LANES         = 4;
  localparam int LANE_W        = 9;
  localparam int WORD_W        = LANES * LANE_W;
  localparam int WORDS         = 524288;
  localparam int FIFO_DEPTH    = 16;
  localparam int FIFO_W        = ADDR_W + LANES + WORD_W;
  localparam int CLK_PERIOD_NS = 100;
  // x36 shape; a x32 build sets this low and parity bits stay unused
  localparam logic PARITY_EN = 1'b1;
  localparam logic OE_N_RST    = 1'b1;
  localparam logic SNOOZE_RST  = 1'b0;
  localparam logic ORDER_N_RST = 1'b1;
  localparam logic [2:0] SYNC_HI_RST = 3'h7;
  localparam logic [2:0] SYNC_LO_RST = 3'h0;
  localparam logic [BURST_W-1:0] BURST_RST  = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [ADDR_W-1:0]  ADDR_RST   = 19'h0;
  localparam logic [WORD_W-1:0]  WORD_RST   = 36'h0;
  localparam logic [LANES-1:0]   ALL_LANES  = 4'hf;
  localparam logic [LANES-1:0]   NO_LANES   = 4'h0;
  localparam logic [4:0]         FIFO_CNT_RST = 5'h0;
  localparam logic [3:0]         FIFO_PTR_RST = 4'h0;

  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } access_t;
endpackage

// ---- hdl/burst_sram.sv ----
// Contract
// - sample synchronous inputs on rising clock only
// - far side presents synchronous inputs at edge
// - core holds half a million 36-bit words
// - two-bit counter makes low burst addresses
// - either address strobe starts a new burst
// - counter steps only when advance is low
// - order pin picks interleaved or linear burst
// - output enable gates the data drivers
// - one shared data bus, driven only on reads
// - one write updates any chosen byte lanes
// - writes finish internally after capture edge
// - narrow shape lane enables gate the byte only
// - each lane enable gates own byte and parity
// - whole-word write low writes every lane
// - parity lanes only on parity-carrying shapes
// - deselect keeps drivers on one extra clock
// - three chip selects, two low one high
// - snooze pin is asynchronous low-power standby
// - snooze keeps contents, ignores other inputs
// - primary select qualifies processor strobe
// - lane enable low means write, gate low permits
// - whole-word write ignores gate and lane enables

////////////////////////////////////////////////////////////////////////
module write_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0]  buf_mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0]   count_reg;
  logic [PW:0]   count_next;
  logic          push;
  logic          pop;
  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);
  assign out_valid  = (count_reg != '0);
  assign out_data   = buf_mem[rd_ptr_reg];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(push);
      rd_ptr_reg <= rd_ptr_reg + PW'(pop);
      count_reg  <= count_next;
      // registered so full is known before the next write arrives
      in_ready   <= (count_next != (PW+1)'(DEPTH));
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
module burst_sram (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [18:0] address,
  input  wire logic        processor_addr_strobe_n,
  input  wire logic        controller_addr_strobe_n,
  input  wire logic        burst_advance_n,
  input  wire logic        chip_select_n,
  input  wire logic        high_select,
  input  wire logic        second_select_n,
  input  wire logic        lane_a_write_n,
  input  wire logic        lane_b_write_n,
  input  wire logic        lane_c_write_n,
  input  wire logic        lane_d_write_n,
  input  wire logic        lane_write_gate_n,
  input  wire logic        whole_word_write_n,
  input  wire logic        output_enable_n,
  input  wire logic        snooze_request,
  input  wire logic        burst_order_select_n,
  input  wire logic [35:0] data_in,
  output logic      [35:0] data_out,
  output logic             data_oe,
  output logic             write_ready
);
  typedef burst_sram_pkg::access_t access_t;
  function automatic logic [1:0] burst_seq(
    input logic [1:0] base,
    input logic [1:0] cnt,
    input logic       linear
  );
    burst_seq = linear ? base + cnt : base ^ cnt;
  endfunction
  function automatic logic [35:0] lane_bits(input logic [3:0] mask);
    lane_bits = burst_sram_pkg::WORD_RST;
    for (int i = 0; i < burst_sram_pkg::LANES; i++) begin
      lane_bits[i*9 +: 8] = {8{mask[i]}};
      lane_bits[i*9 + 8]  = mask[i] & burst_sram_pkg::PARITY_EN;
    end
  endfunction
  logic [35:0]   mem [burst_sram_pkg::WORDS];
  logic [2:0]    oe_sync_reg;
  logic [2:0]    snz_sync_reg;
  logic [2:0]    ord_sync_reg;
  logic          oe_n_reg;
  logic          snz_reg;
  logic          ord_n_reg;
  access_t       acc_reg;
  access_t       acc_next;
  logic [16:0]   upper_reg;
  logic [16:0]   upper_next;
  logic [1:0]    base_reg;
  logic [1:0]    base_next;
  logic [1:0]    cnt_reg;
  logic [1:0]    cnt_next;
  logic          rd_vis_reg;
  logic          fifo_ready;
  logic          drain_valid;
  logic [58:0]   drain_data;

  ////////////////////////////////////////////////////////////////////
  // pins from outside the clock domain: three stages, 2nd/3rd agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_sync_reg  <= burst_sram_pkg::SYNC_HI_RST;
      snz_sync_reg <= burst_sram_pkg::SYNC_LO_RST;
      ord_sync_reg <= burst_sram_pkg::SYNC_HI_RST;
      oe_n_reg     <= burst_sram_pkg::OE_N_RST;
      snz_reg      <= burst_sram_pkg::SNOOZE_RST;
      ord_n_reg    <= burst_sram_pkg::ORDER_N_RST;
    end else begin
      oe_sync_reg  <= {oe_sync_reg[1:0], output_enable_n};
      snz_sync_reg <= {snz_sync_reg[1:0], snooze_request};
      ord_sync_reg <= {ord_sync_reg[1:0], burst_order_select_n};
      if (oe_sync_reg[1] == oe_sync_reg[2])
        oe_n_reg <= oe_sync_reg[2];
      if (snz_sync_reg[1] == snz_sync_reg[2])
        snz_reg <= snz_sync_reg[2];
      if (ord_sync_reg[1] == ord_sync_reg[2])
        ord_n_reg <= ord_sync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // access decode
  wire       ce_ok   = ~chip_select_n & high_select & ~second_select_n;
  wire       p_load  = ~processor_addr_strobe_n & ~chip_select_n;
  wire       c_load  = ~controller_addr_strobe_n;
  wire       load    = p_load | c_load;
  wire [3:0] lanes_n = {lane_d_write_n, lane_c_write_n,
                        lane_b_write_n, lane_a_write_n};
  wire [3:0] gated   = lane_write_gate_n ? burst_sram_pkg::NO_LANES
                                         : ~lanes_n;
  wire [3:0] wr_mask = whole_word_write_n ? gated
                       : burst_sram_pkg::ALL_LANES;
  wire       wr_req  = |wr_mask;
  wire       active  = (acc_reg != burst_sram_pkg::ACC_IDLE);
  wire       linear  = ~ord_n_reg;
  // processor strobe with all three selects active always opens a read; writes follow in later cycles
  wire       p_read  = p_load & ce_ok;
  wire       adv     = ~load & active & ~burst_advance_n;

  always_comb begin
    acc_next   = acc_reg;
    upper_next = upper_reg;
    base_next  = base_reg;
    cnt_next   = cnt_reg;
    if (load) begin
      upper_next = address[18:2];
      base_next  = address[1:0];
      cnt_next   = burst_sram_pkg::BURST_RST;
      if (!ce_ok)
        acc_next = burst_sram_pkg::ACC_IDLE;
      else if (p_read || !wr_req)
        acc_next = burst_sram_pkg::ACC_READ;
      else
        acc_next = burst_sram_pkg::ACC_WRITE;
    end else if (active) begin
      cnt_next = adv ? cnt_reg + burst_sram_pkg::BURST_STEP : cnt_reg;
      acc_next = wr_req ? burst_sram_pkg::ACC_WRITE
                        : burst_sram_pkg::ACC_READ;
    end
  end

  wire [1:0]  off_now   = burst_seq(base_reg, cnt_reg, linear);
  wire [1:0]  off_next  = burst_seq(base_next, cnt_next, linear);
  wire [18:0] addr_now  = {upper_reg, off_now};
  wire [18:0] addr_next = {upper_next, off_next};
  wire        wr_next   = (acc_next == burst_sram_pkg::ACC_WRITE);
  // a write into a full buffer, or snooze, freezes the whole cycle
  wire        stall     = snz_reg | (wr_next & ~fifo_ready);
  wire        take      = ~stall;
  wire        push      = take & wr_next;
  wire [3:0]  push_mask = (p_load & ce_ok) ? burst_sram_pkg::NO_LANES
                                           : wr_mask;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg   <= burst_sram_pkg::ACC_IDLE;
      upper_reg <= 17'h0;
      base_reg  <= burst_sram_pkg::BURST_RST;
      cnt_reg   <= burst_sram_pkg::BURST_RST;
    end else if (take) begin
      acc_reg   <= acc_next;
      upper_reg <= upper_next;
      base_reg  <= base_next;
      cnt_reg   <= cnt_next;
    end
  end

  // write data and controls queued so the array write is self-timed
  write_fifo #(
    .W     (burst_sram_pkg::FIFO_W),
    .DEPTH (burst_sram_pkg::FIFO_DEPTH)
  ) u_wbuf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({addr_next, push_mask, data_in}),
    .out_valid (drain_valid),
    .out_ready (~snz_reg),
    .out_data  (drain_data)
  );

  wire [18:0] drain_addr = drain_data[58:40];
  wire [35:0] drain_bits = lane_bits(drain_data[39:36]);
  wire        drain_go   = drain_valid & ~snz_reg;
  // limitation: a read of a word still queued sees the old contents;
  // with an idle queue a write is in the array before the next read
  always_ff @(posedge clk) begin
    if (drain_go) begin
      mem[drain_addr] <= (mem[drain_addr] & ~drain_bits)
                       | (drain_data[35:0] & drain_bits);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output pipeline
  wire rd_now = (acc_reg == burst_sram_pkg::ACC_READ);
  wire hold   = rd_vis_reg & (acc_reg == burst_sram_pkg::ACC_IDLE);
  wire oe_on  = ~oe_n_reg & ~snz_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out    <= burst_sram_pkg::WORD_RST;
      data_oe     <= 1'b0;
      rd_vis_reg  <= 1'b0;
      write_ready <= 1'b0;
    end else begin
      if (rd_now && !snz_reg)
        data_out <= mem[addr_now];
      data_oe     <= oe_on & (rd_now | hold);
      rd_vis_reg  <= take ? rd_now : rd_vis_reg;
      write_ready <= fifo_ready & ~snz_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_read_go;
    take && acc_next == burst_sram_pkg::ACC_READ;
  endsequence
  property p_read_drive;
    s_read_go ##1 (take && oe_on) |=> data_oe;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read not driven one edge after capture");
  property p_write_quiet;
    acc_reg == burst_sram_pkg::ACC_WRITE && !hold |=> !data_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("bus driven during write cycle");
  property p_deselect_hold;
    rd_vis_reg && acc_reg == burst_sram_pkg::ACC_IDLE && oe_on
      |=> data_oe;
  endproperty
  a_deselect_hold: assert property (p_deselect_hold)
    else $error("drivers dropped without extra cycle");
  property p_linear_step;
    take && adv && linear ##1 linear
      |-> off_now == $past(off_now) + burst_sram_pkg::BURST_STEP;
  endproperty
  a_linear_step: assert property (p_linear_step)
    else $error("linear burst did not count up");
  property p_hold_count;
    take && !load && burst_advance_n |=> $stable(cnt_reg);
  endproperty
  a_hold_count: assert property (p_hold_count)
    else $error("burst counter moved without advance");
  property p_snooze_freeze;
    snz_reg |=> $stable(acc_reg) && $stable(cnt_reg) && !data_oe;
  endproperty
  a_snooze_freeze: assert property (p_snooze_freeze)
    else $error("state changed during snooze");
  property p_whole_word;
    push && !whole_word_write_n && !(p_load && ce_ok)
      |-> push_mask == burst_sram_pkg::ALL_LANES;
  endproperty
  a_whole_word: assert property (p_whole_word)
    else $error("whole-word write missed a lane");
  property p_gate_blocks;
    take && whole_word_write_n && lane_write_gate_n |-> !push;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks)
    else $error("write queued with gate high");
  // an unqualified processor strobe would reload the burst position
  property p_strobe_qualified;
    !processor_addr_strobe_n && chip_select_n && controller_addr_strobe_n
      && burst_advance_n && take
      |=> $stable(cnt_reg) && $stable(base_reg) && $stable(upper_reg);
  endproperty
  a_strobe_qualified: assert property (p_strobe_qualified)
    else $error("processor strobe acted without select");
  property p_drain;
    drain_valid && !snz_reg ##1 !snz_reg
      |-> !$stable(drain_data) || !drain_valid || $past(push);
  endproperty
  a_drain: assert property (p_drain)
    else $error("write buffer did not drain");
endmodule

// ---- sim/bus_ctl_model.sv ----
module bus_ctl_model (
  input  wire logic        clk,
  input  wire logic [35:0] data_out,
  input  wire logic        data_oe,
  output logic      [35:0] data_in,
  output logic      [18:0] address,
  output logic             processor_addr_strobe_n,
  output logic             controller_addr_strobe_n,
  output logic             burst_advance_n,
  output logic             chip_select_n,
  output logic             high_select,
  output logic             second_select_n,
  output logic             lane_a_write_n,
  output logic             lane_b_write_n,
  output logic             lane_c_write_n,
  output logic             lane_d_write_n,
  output logic             lane_write_gate_n,
  output logic             whole_word_write_n,
  output logic             output_enable_n,
  output logic             snooze_request,
  output logic             burst_order_select_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [35:0] drv;
  logic [2:0]  sel;
  logic [3:0]  lanes_n;
  logic        own;
  // shared bus: our write data wins over a read still being driven
  assign data_in = (data_oe && !own) ? data_out : drv;
  assign {chip_select_n, high_select, second_select_n} = sel;
  assign {lane_d_write_n, lane_c_write_n} = lanes_n[3:2];
  assign {lane_b_write_n, lane_a_write_n} = lanes_n[1:0];
  ////////////////////////////////////////////////////////////////////////
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic quiet(input logic adv);
    {processor_addr_strobe_n, controller_addr_strobe_n} = 2'h3;
    burst_advance_n = adv;
    own = 1'b0;
    {whole_word_write_n, lane_write_gate_n, lanes_n} = 6'h3f;
  endtask
  task automatic step(input logic adv);
    quiet(adv);
    drv = ~drv; // released bus must not keep its last value
    cyc();
  endtask
  task automatic load(input logic p, input logic [18:0] a,
                      input logic [2:0] s, input logic [5:0] w,
                      input logic [35:0] d);
    processor_addr_strobe_n = !p;
    controller_addr_strobe_n = p;
    burst_advance_n = 1'b1;
    address = a;
    sel = s;
    {whole_word_write_n, lane_write_gate_n, lanes_n} = w;
    drv = (w == 6'h3f) ? ~drv : d;
    own = (w != 6'h3f);
    cyc();
  endtask
  task automatic pins(input logic [2:0] v);
    {output_enable_n, snooze_request, burst_order_select_n} = v;
    // pins pass a three-stage synchroniser inside
    repeat (5) step(1'b1);
  endtask
  initial begin
    drv = 36'h0;
    address = 19'h0;
    sel = 3'h2;
    {output_enable_n, snooze_request, burst_order_select_n} = 3'h1;
    quiet(1'b1);
  end
endmodule

// ---- sim/test_pipelined_burst_sram_port.sv ----
module test_pipelined_burst_sram_port;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [18:0] BASE = 19'h1a4;
  logic        clk;
  logic        rst;
  wire  [18:0] address;
  wire  [35:0] data_in, data_out;
  wire         processor_addr_strobe_n, controller_addr_strobe_n;
  wire         burst_advance_n, chip_select_n, high_select, second_select_n;
  wire         lane_a_write_n, lane_b_write_n, lane_c_write_n;
  wire         lane_d_write_n, lane_write_gate_n, whole_word_write_n;
  wire         output_enable_n, snooze_request, burst_order_select_n;
  wire         data_oe, write_ready;
  int          n_fail = 0;
  int          total_checks = 0;

  burst_sram dut (
    .clk, .rst, .address, .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .chip_select_n, .high_select, .second_select_n,
    .lane_a_write_n, .lane_b_write_n, .lane_c_write_n, .lane_d_write_n,
    .lane_write_gate_n, .whole_word_write_n, .output_enable_n,
    .snooze_request, .burst_order_select_n, .data_in, .data_out, .data_oe,
    .write_ready
  );
  bus_ctl_model ctl (
    .clk, .address, .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .chip_select_n, .high_select, .second_select_n,
    .lane_a_write_n, .lane_b_write_n, .lane_c_write_n, .lane_d_write_n,
    .lane_write_gate_n, .whole_word_write_n, .output_enable_n,
    .snooze_request, .burst_order_select_n, .data_in, .data_out, .data_oe
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [35:0] pat(input logic [18:0] a);
    return {a[17:0], ~a[17:0]};
  endfunction
  task automatic chk(input string what, input logic [35:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic rd(input logic [18:0] a, input logic [35:0] e,
                    input string what);
    ctl.load(1'b0, a, 3'h2, 6'h3f, 36'h0);
    ctl.step(1'b1);
    chk(what, e, data_out);
    chk("drive enable", 36'h1, {35'h0, data_oe});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_whole();
    chk("write ready", 36'h1, {35'h0, write_ready});
    // lanes a and b low with gate high: whole-word write still takes all
    for (int i = 0; i < 4; i++) begin
      ctl.load(1'b0, BASE + 19'(i), 3'h2, 6'h1c, pat(BASE + 19'(i)));
    end
    ctl.step(1'b1);
    for (int i = 0; i < 4; i++) begin
      rd(BASE + 19'(i), pat(BASE + 19'(i)), "whole word");
    end
    $display("done whole word writes");
  endtask
  task automatic t_burst(input logic ord);
    logic [1:0] lo;
    ctl.pins({2'h0, ord});
    ctl.load(ord, BASE + 19'h1, 3'h2, 6'h3f, 36'h0);
    for (int k = 0; k < 5; k++) begin
      ctl.step(k < 3 ? 1'b0 : 1'b1);
      lo = (k > 3) ? 2'h3 : 2'(k);
      lo = ord ? (2'h1 ^ lo) : (2'h1 + lo);
      chk("burst word", pat(BASE + 19'(lo)), data_out);
    end
    // processor strobe with primary select high must leave the burst alone
    ctl.load(1'b1, BASE + 19'h1, 3'h6, 6'h3f, 36'h0);
    ctl.step(1'b1);
    chk("strobe without select", pat(BASE + 19'(lo)), data_out);
    $display("done burst order %0d", ord);
  endtask
  task automatic t_lanes();
    logic [35:0] exp;
    logic [3:0]  ln;
    exp = pat(BASE);
    for (int i = 0; i < 4; i++) begin
      ln = ~(4'h1 << i);
      ctl.load(1'b0, BASE, 3'h2, {2'h2, ln}, 36'hf_ffff_ffff);
      exp[9*i +: 9] = 9'h1ff;
      ctl.step(1'b1);
      rd(BASE, exp, "lane write");
    end
    ctl.load(1'b0, BASE, 3'h2, 6'h30, 36'h0);
    ctl.step(1'b1);
    rd(BASE, exp, "gate closed");
    $display("done lane writes");
  endtask
  task automatic t_desel();
    logic [2:0] s;
    for (int i = 0; i < 3; i++) begin
      s = 3'h2 ^ (3'h1 << i);
      ctl.load(1'b0, BASE + 19'h2, 3'h2, 6'h3f, 36'h0);
      ctl.load(1'b0, BASE + 19'h2, s, 6'h3f, 36'h0);
      chk("last read", pat(BASE + 19'h2), data_out);
      ctl.step(1'b1);
      chk("extra drive", 36'h1, {35'h0, data_oe});
      ctl.step(1'b1);
      chk("drive off", 36'h0, {35'h0, data_oe});
    end
    $display("done deselect");
  endtask
  task automatic t_oe();
    ctl.pins(3'h5);
    ctl.load(1'b0, BASE, 3'h2, 6'h3f, 36'h0);
    ctl.step(1'b1);
    chk("drive while disabled", 36'h0, {35'h0, data_oe});
    ctl.pins(3'h1);
    rd(BASE + 19'h3, pat(BASE + 19'h3), "enable back");
    $display("done output enable");
  endtask
  task automatic t_snooze();
    ctl.pins(3'h3);
    chk("ready in snooze", 36'h0, {35'h0, write_ready});
    ctl.load(1'b0, BASE + 19'h3, 3'h2, 6'h1f, 36'h0);
    ctl.pins(3'h1);
    for (int i = 0; i < 20 && write_ready !== 1'b1; i++) begin
      ctl.step(1'b1);
    end
    if (write_ready !== 1'b1) begin
      n_fail++;
      $display("mismatch write ready expected 1 seen %b", write_ready);
      tally_and_finish();
    end
    rd(BASE + 19'h3, pat(BASE + 19'h3), "kept in snooze");
    $display("done snooze");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    ctl.pins(3'h1);
    t_whole();
    t_burst(1'b0);
    t_burst(1'b1);
    t_lanes();
    t_desel();
    t_oe();
    t_snooze();
    tally_and_finish();
  end
endmodule
